// ==== core/ctm_regs.vh ====
`ifndef CTM_REGS_VH
`define CTM_REGS_VH

// Register byte addresses on the bus.
`define CTM_ADDR_RELOAD 32'hffff0380
`define CTM_ADDR_LIVE 32'hffff0384
`define CTM_ADDR_CONFIG 32'hffff0388
`define CTM_ADDR_CLEAR 32'hffff038c
`define CTM_ADDR_CAPTURE 32'hffff0390
`define CTM_ADDR_STATUS 32'hffff0394
`define CTM_ADDR_MASK 32'hffff0398

// Reset values.
`define CTM_RST_RELOAD 16'h0000
`define CTM_RST_LIVE 16'hffff
`define CTM_RST_CONFIG 32'h00000000
`define CTM_RST_CAPTURE 16'h0000

// Configuration field positions.
`define CTM_CFG_PRESC_LO 0
`define CTM_CFG_PRESC_HI 3
`define CTM_CFG_PERIODIC 6
`define CTM_CFG_ENABLE 7
`define CTM_CFG_COUNT_UP 8
`define CTM_CFG_CLK_SEL 9
`define CTM_CFG_EVSEL_LO 12
`define CTM_CFG_EVSEL_HI 16
`define CTM_CFG_CAPT_EN 17
// Writable bits of the configuration register; the rest read zero.
`define CTM_CFG_WMASK 32'h0003f3cf

// Prescaler codes and their last count values.
`define CTM_PRE_DIV1 4'h0
`define CTM_PRE_DIV16 4'h4
`define CTM_PRE_DIV256 4'h8
`define CTM_PRE_DIV32768 4'hf
`define CTM_PRE_LAST16 15'h000f
`define CTM_PRE_LAST256 15'h00ff
`define CTM_PRE_LAST32768 15'h7fff

// Interrupt status bit positions.
`define CTM_ST_TIMEOUT 0
`define CTM_ST_CAPTURE 1

// Number of selectable interrupt sources for capture.
`define CTM_EVENT_COUNT 18

`endif

// ==== core/ctm_prescaler.v ====
`timescale 1ns/1ps
`include "ctm_regs.vh"

module ctm_prescaler #(
  parameter CNT_W = 15
) (
  input wire ref_clk, // Core clock.
  input wire srst, // Synchronous reset, active high.
  input wire run, // Counter enabled; low holds the divider at zero.
  input wire srcTick, // One pulse per source clock period.
  input wire [3:0] preSel, // Prescaler code.
  output wire divTick // One pulse per divided period.
);

  reg [CNT_W-1:0] divCount_reg;
  reg [CNT_W-1:0] divCount_next;
  wire [CNT_W-1:0] lastCount;
  wire atLast;

  // Map a prescaler code to the last value of the divider.
  function [CNT_W-1:0] ctmDivLast;
    input [3:0] code;
    begin
      case (code)
        `CTM_PRE_DIV16: ctmDivLast = `CTM_PRE_LAST16;
        `CTM_PRE_DIV256: ctmDivLast = `CTM_PRE_LAST256;
        `CTM_PRE_DIV32768: ctmDivLast = `CTM_PRE_LAST32768;
        default: ctmDivLast = {CNT_W{1'b0}};
      endcase
    end
  endfunction

  assign lastCount = ctmDivLast(preSel);
  // Compare with >= so a code change mid-period cannot strand the divider.
  assign atLast = (divCount_reg >= lastCount);
  assign divTick = run & srcTick & atLast;

  // Divider count advances on each source tick.
  always @* begin
    divCount_next = divCount_reg;
    if (!run) begin
      divCount_next = {CNT_W{1'b0}};
    end else if (srcTick) begin
      if (atLast) begin
        divCount_next = {CNT_W{1'b0}};
      end else begin
        divCount_next = divCount_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Divider state register.
  always @(posedge ref_clk) begin
    if (srst) begin
      divCount_reg <= {CNT_W{1'b0}};
    end else begin
      divCount_reg <= divCount_next;
    end
  end

endmodule // ctm_prescaler

// ==== core/ctm_event_edge.v ====
`timescale 1ns/1ps
`include "ctm_regs.vh"

module ctm_event_edge #(
  parameter N = `CTM_EVENT_COUNT,
  parameter SEL_W = 5
) (
  input wire ref_clk, // Core clock.
  input wire srst, // Synchronous reset, active high.
  input wire [N-1:0] sources, // Interrupt source levels.
  input wire [SEL_W-1:0] sel, // Selected source number.
  input wire armed, // Capture enabled.
  output wire hit // One-cycle pulse on a first assertion.
);

  // Highest valid source number, cut to the select width on purpose.
  localparam [31:0] LAST_FULL = N - 1;
  localparam [SEL_W-1:0] LAST_SEL = LAST_FULL[SEL_W-1:0];

  reg [N-1:0] prev_reg;
  wire [N-1:0] rise;

  // Rising edge of every source, so only the initial assertion counts.
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_rise
      assign rise[i] = sources[i] & ~prev_reg[i];
    end
  endgenerate

  assign hit = armed && (sel <= LAST_SEL) && rise[sel];

  // Previous levels of all sources.
  always @(posedge ref_clk) begin
    if (srst) begin
      prev_reg <= {N{1'b0}};
    end else begin
      prev_reg <= sources;
    end
  end

endmodule // ctm_event_edge

// ==== core/ctm_capture_timer.v ====
// Behaviour
// - 16-bit counter, bit 8 up, else down
// - Bit 7 enables counting, default off
// - Bit 6 periodic, clear free running
// - Bit 9 selects core or 32 kHz
// - Prescaler code divides by 1/16/256/32768
// - First event edge copies count, keeps running
// - Capture only while bit 17 set
// - Bits 16:12 pick source 0 to 17
// - Any clear-register write clears timeout flag
// - Live count readable, resets to ffff
// - Reload register read/write, resets zero
// - Output pulse paces serial test interface
`timescale 1ns/1ps
`include "ctm_regs.vh"

module ctm_capture_timer #(
  parameter EV_N = `CTM_EVENT_COUNT
) (
  input wire ref_clk, // Core clock, 200 MHz.
  input wire srst, // Synchronous reset, active high.
  input wire [31:0] wb_adr_i, // Bus byte address.
  input wire [31:0] wb_dat_i, // Bus write data.
  output wire [31:0] wb_dat_o, // Bus read data.
  input wire wb_we_i, // Write strobe.
  input wire [3:0] wb_sel_i, // Byte lane selects.
  input wire wb_cyc_i, // Bus cycle.
  input wire wb_stb_i, // Bus strobe.
  output wire wb_ack_o, // Bus acknowledge.
  input wire lowPowerOsc, // 32.768 kHz oscillator level.
  input wire [EV_N-1:0] irqSources, // Interrupt sources for capture.
  output wire serialTestTick, // Pacing pulse for serial test interface.
  output wire timerIrq // Interrupt, active high level.
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  reg ack_reg;
  reg [31:0] rdData_reg;
  reg [31:0] rdData_next;
  reg [15:0] reload_reg;
  reg [15:0] reload_next;
  reg [15:0] live_reg;
  reg [15:0] live_next;
  reg [31:0] config_reg;
  reg [31:0] config_next;
  reg [15:0] capture_reg;
  reg [15:0] capture_next;
  reg [1:0] status_reg;
  reg [1:0] status_next;
  reg [1:0] mask_reg;
  reg [1:0] mask_next;
  reg oscPrev_reg;
  reg stiTick_reg;
  reg expire;
  reg [31:0] reloadMerged;
  wire request;
  wire writeNow;
  wire oscRise;
  wire srcTick;
  wire countTick;
  wire captureHit;
  wire countUp;
  wire countRun;
  wire periodic;
  wire [1:0] events;
  wire [1:0] w1cBits;
  wire clearStrobe;
  wire hitReload;
  wire hitConfig;
  wire hitMask;
  wire hitClear;
  wire hitStatus;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Merge write data into a word under byte lane selects.
  function [31:0] ctmMerge;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0] lanes;
    integer b;
    begin
      ctmMerge = oldVal;
      for (b = 0; b < 4; b = b + 1) begin
        if (lanes[b]) begin
          ctmMerge[b*8 +: 8] = newVal[b*8 +: 8];
        end
      end
    end
  endfunction

  // True when a write of the current request hits the given address.
  // Everything it reads is an argument, so a caller sees every change.
  function ctmWriteHit;
    input wrReq;
    input [31:0] busAdr;
    input [31:0] addr;
    begin
      ctmWriteHit = wrReq && (busAdr == addr);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave handshake.

  // A request is answered one cycle after it is seen; ack then drops for a
  // cycle, so back-to-back requests each get exactly one ack.
  assign request = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master samples ack.
  assign writeNow = request & wb_we_i & ack_reg;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdData_reg;

  // Register write decodes, each shared by the processes that need it.
  assign hitReload = ctmWriteHit(writeNow, wb_adr_i, `CTM_ADDR_RELOAD);
  assign hitConfig = ctmWriteHit(writeNow, wb_adr_i, `CTM_ADDR_CONFIG);
  assign hitMask = ctmWriteHit(writeNow, wb_adr_i, `CTM_ADDR_MASK);
  assign hitClear = ctmWriteHit(writeNow, wb_adr_i, `CTM_ADDR_CLEAR);
  assign hitStatus = ctmWriteHit(writeNow, wb_adr_i, `CTM_ADDR_STATUS);

  // Read data is sampled with the request; unmapped reads return zero.
  // Write-only addresses read zero too, so no stale word leaks out.
  always @* begin
    rdData_next = rdData_reg;
    if (request && !ack_reg) begin
      case (wb_adr_i)
        `CTM_ADDR_RELOAD: rdData_next = {16'h0000, reload_reg};
        `CTM_ADDR_LIVE: rdData_next = {16'h0000, live_reg};
        `CTM_ADDR_CONFIG: rdData_next = config_reg;
        `CTM_ADDR_CAPTURE: rdData_next = {16'h0000, capture_reg};
        `CTM_ADDR_STATUS: rdData_next = {30'h0, status_reg};
        `CTM_ADDR_MASK: rdData_next = {30'h0, mask_reg};
        default: rdData_next = 32'h00000000;
      endcase
    end
  end

  // Acknowledge and read data registers.
  always @(posedge ref_clk) begin
    if (srst) begin
      ack_reg <= 1'b0;
      rdData_reg <= 32'h00000000;
    end else begin
      ack_reg <= request & ~ack_reg;
      rdData_reg <= rdData_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-written registers.

  // Reload, configuration and mask registers take byte-lane writes.
  always @* begin
    reload_next = reload_reg;
    config_next = config_reg;
    mask_next = mask_reg;
    // The merge is 32 bits wide; only its low half belongs to the register.
    reloadMerged = ctmMerge({16'h0000, reload_reg}, wb_dat_i, wb_sel_i);
    if (hitReload) begin
      reload_next = reloadMerged[15:0];
    end
    // Reserved configuration bits are forced low so they read zero.
    if (hitConfig) begin
      config_next = ctmMerge(config_reg, wb_dat_i, wb_sel_i) &
        `CTM_CFG_WMASK;
    end
    if (hitMask && wb_sel_i[0]) begin
      mask_next = wb_dat_i[1:0];
    end
  end

  // Register storage for software controls.
  always @(posedge ref_clk) begin
    if (srst) begin
      reload_reg <= `CTM_RST_RELOAD;
      config_reg <= `CTM_RST_CONFIG;
      mask_reg <= 2'h0;
    end else begin
      reload_reg <= reload_next;
      config_reg <= config_next;
      mask_reg <= mask_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count source and prescaler.

  // source clock select
  // The oscillator pin is taken as synchronous, so its rising edge is
  // detected directly; each edge is one source period.
  assign oscRise = lowPowerOsc & ~oscPrev_reg;
  assign srcTick = config_reg[`CTM_CFG_CLK_SEL] ? oscRise : 1'b1;
  // enable gating
  // Disabling also restarts the prescaler, so each run starts afresh.
  assign countRun = config_reg[`CTM_CFG_ENABLE];
  assign countUp = config_reg[`CTM_CFG_COUNT_UP];
  assign periodic = config_reg[`CTM_CFG_PERIODIC];

  // Oscillator edge detector.
  always @(posedge ref_clk) begin
    if (srst) begin
      oscPrev_reg <= 1'b0;
    end else begin
      oscPrev_reg <= lowPowerOsc;
    end
  end

  ctm_prescaler #(
    .CNT_W(15)
  ) ctm_prescaler_inst (
    .ref_clk(ref_clk),
    .srst(srst),
    .run(countRun),
    .srcTick(srcTick),
    .preSel(config_reg[`CTM_CFG_PRESC_HI:`CTM_CFG_PRESC_LO]),
    .divTick(countTick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counter.

  // A write to the reload register also loads the counter; that write
  // wins over a tick in the same cycle, so software sees its value.
  always @* begin
    live_next = live_reg;
    expire = 1'b0;
    if (hitReload) begin
      live_next = reload_next;
    end else if (countTick) begin
      if (countUp) begin
        expire = (live_reg == 16'hffff);
        live_next = live_reg + 16'h0001;
      end else begin
        expire = (live_reg == 16'h0000);
        live_next = live_reg - 16'h0001;
      end
      if (expire && periodic) begin
        live_next = reload_reg;
      end
    end
  end

  // Counter register.
  always @(posedge ref_clk) begin
    if (srst) begin
      live_reg <= `CTM_RST_LIVE;
    end else begin
      live_reg <= live_next;
    end
  end

  // serial test pacing
  // Registered so the peripheral sees a clean one-cycle pulse per expiry.
  always @(posedge ref_clk) begin
    if (srst) begin
      stiTick_reg <= 1'b0;
    end else begin
      stiTick_reg <= expire;
    end
  end

  assign serialTestTick = stiTick_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Event capture.

  ctm_event_edge #(
    .N(EV_N),
    .SEL_W(5)
  ) ctm_event_edge_inst (
    .ref_clk(ref_clk),
    .srst(srst),
    .sources(irqSources),
    .sel(config_reg[`CTM_CFG_EVSEL_HI:`CTM_CFG_EVSEL_LO]),
    .armed(config_reg[`CTM_CFG_CAPT_EN]),
    .hit(captureHit)
  );

  // capture live count
  // The counter itself is untouched, so timing keeps running.
  always @* begin
    capture_next = capture_reg;
    if (captureHit) begin
      capture_next = live_reg;
    end
  end

  // Capture register.
  always @(posedge ref_clk) begin
    if (srst) begin
      capture_reg <= `CTM_RST_CAPTURE;
    end else begin
      capture_reg <= capture_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status.

  assign events = {captureHit, expire};
  // any write clears
  // Data and lanes are ignored: any write to the strobe clears timeout.
  assign clearStrobe = hitClear;
  // A status write with lane 0 low leaves both flags alone.
  assign w1cBits = (hitStatus && wb_sel_i[0]) ? wb_dat_i[1:0] : 2'h0;

  // sticky timeout flag
  // Clears first and sets last, so an event in the clearing cycle survives.
  always @* begin
    status_next = status_reg & ~w1cBits;
    if (clearStrobe) begin
      status_next[`CTM_ST_TIMEOUT] = 1'b0;
    end
    status_next = status_next | events;
  end

  // Status register.
  always @(posedge ref_clk) begin
    if (srst) begin
      status_reg <= 2'h0;
    end else begin
      status_reg <= status_next;
    end
  end

  // Level interrupt while any unmasked status bit is set.
  // The mask resets to zero, so software unmasks before it sees a timeout.
  assign timerIrq = |(status_reg & mask_reg);

endmodule // ctm_capture_timer

// ==== tb/ctm_capture_timer_chk.sv ====
`timescale 1ns/1ps
`include "ctm_regs.vh"
module ctm_capture_timer_chk (
  input wire ref_clk, // Clock.
  input wire srst, // Reset.
  input wire [31:0] wb_adr_i, // Address.
  input wire [31:0] wb_dat_i, // Write data.
  input wire [31:0] wb_dat_o, // Read data.
  input wire wb_we_i, // Write.
  input wire [3:0] wb_sel_i, // Lanes.
  input wire wb_cyc_i, // Cycle.
  input wire wb_stb_i, // Strobe.
  input wire wb_ack_o, // Acknowledge.
  input wire serialTestTick, // Pacing.
  input wire timerIrq // Interrupt.
);
  reg [1:0] maskCopy_reg;
  ///////////////////////////////
  // Shadow of the mask, since the interrupt output depends on it.
  always @(posedge ref_clk) begin
    if (srst)
      maskCopy_reg <= 2'h0;
    else if (wb_ack_o && wb_we_i && wb_sel_i[0] &&
             wb_adr_i == `CTM_ADDR_MASK)
      maskCopy_reg <= wb_dat_i[1:0];
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence sReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence sRd;
    wb_ack_o && !wb_we_i;
  endsequence
  sequence sClr;
    wb_ack_o && wb_we_i && wb_adr_i == `CTM_ADDR_CLEAR;
  endsequence
  a_ack_answer: assert property (sReq |=> wb_ack_o)
    else $error("Request not answered.");
  a_clear_reads: assert property (sRd ##0
    (wb_adr_i == `CTM_ADDR_CLEAR) |-> wb_dat_o == 32'h0)
    else $error("Clear strobe read not zero.");
  a_cfg_reserved: assert property (sRd ##0
    (wb_adr_i == `CTM_ADDR_CONFIG) |-> (wb_dat_o & ~`CTM_CFG_WMASK) == 0)
    else $error("Reserved config bits set.");
  a_upper_zero: assert property (sRd ##0 (wb_adr_i ==
    `CTM_ADDR_LIVE || wb_adr_i == `CTM_ADDR_CAPTURE) |-> !(|wb_dat_o[31:16]))
    else $error("Upper half not zero.");
  a_irq_masked: assert property (maskCopy_reg == 2'h0 |-> !timerIrq)
    else $error("Interrupt with mask clear.");
  a_tick_irq: assert property (serialTestTick && maskCopy_reg[0]
    |-> timerIrq) else $error("Expiry without interrupt.");
  a_irq_sticky: assert property (timerIrq &&
    !(wb_ack_o && wb_we_i) |=> timerIrq) else $error("Interrupt dropped.");
  a_clear_drops: assert property (sClr ##1
    (!serialTestTick && !maskCopy_reg[1]) |-> !timerIrq)
    else $error("Clear did not drop interrupt.");
endmodule // ctm_capture_timer_chk

bind ctm_capture_timer ctm_capture_timer_chk ctm_capture_timer_chk_inst (
  .ref_clk(ref_clk), .srst(srst), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
  .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .serialTestTick(serialTestTick),
  .timerIrq(timerIrq)
);

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`include "ctm_regs.vh"
module tb_top;
  reg ref_clk = 1'b0;
  reg srst = 1'b1;
  reg [31:0] wb_adr_i = 32'h0;
  reg [31:0] wb_dat_i = 32'h0;
  reg wb_we_i = 1'b0;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg [3:0] wb_sel_i = 4'h0;
  reg lowPowerOsc = 1'b0;
  reg [17:0] irqSources = 18'h0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire serialTestTick;
  wire timerIrq;
  reg [31:0] rd;
  integer fails = 0;
  integer cmp_count = 0;
  integer cycles = 0;
  integer ticks = 0;
  integer i;
  reg [63:0] ldT = {16'hfffe, 16'hffff, 16'h0001, 16'h0001};
  reg [47:0] cfT = {12'h1c0, 12'h180, 12'h0c0, 12'h080};
  reg [63:0] exT = {16'hffff, 16'h0002, 16'h0000, 16'hfffe};
  reg [15:0] preT = {4'h0, 4'h4, 4'h8, 4'hf};
  reg [31:0] decT = {8'h17, 8'h01, 8'h01, 8'h00};
  reg [127:0] ccT = {32'h31000, 32'h25000, 32'h05000, 32'h25000};
  reg [63:0] clT = {16'h0400, 16'h0300, 16'h0200, 16'h0100};
  reg [19:0] csT = {5'h11, 5'h06, 5'h05, 5'h05};
  reg [63:0] cxT = {16'h0400, 16'h0100, 16'h0100, 16'h0100};

  ctm_capture_timer ctm_capture_timer_inst (
    .ref_clk(ref_clk), .srst(srst), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .lowPowerOsc(lowPowerOsc),
    .irqSources(irqSources), .serialTestTick(serialTestTick),
    .timerIrq(timerIrq)
  );

  // Core clock at 200 MHz.
  always #2.5 ref_clk = ~ref_clk;

  // Hang guard, and a count of pacing pulses.
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (serialTestTick === 1'b1)
      ticks = ticks + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      report_and_stop;
    end
  end

  ///////////////////////////////
  task report_and_stop;
    begin
      $display("Compares %0d, mismatches %0d.", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  task chk(input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  endtask

  // Holds the request until ack is sampled, so no edge is missed.
  task xfer(input w, input [31:0] a, input [31:0] d);
    begin
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_sel_i <= 4'hf;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge ref_clk);
      while (wb_ack_o !== 1'b1)
        @(posedge ref_clk);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_sel_i <= 4'h0;
      wb_we_i <= 1'b0;
    end
  endtask

  task rdchk(input [31:0] a, input [31:0] e);
    begin
      xfer(1'b0, a, 32'h0);
      chk(e, rd);
    end
  endtask

  // Waits one edge so the last write has landed.
  task irqchk(input e);
    begin
      @(posedge ref_clk);
      chk({31'h0, e}, {31'h0, timerIrq});
    end
  endtask

  task pulse(input integer n);
    begin
      @(posedge ref_clk);
      irqSources[n] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      irqSources[n] <= 1'b0;
    end
  endtask

  ///////////////////////////////
  initial begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    rdchk(`CTM_ADDR_RELOAD, 32'h0);
    rdchk(`CTM_ADDR_CONFIG, 32'h0);
    rdchk(`CTM_ADDR_CAPTURE, 32'h0);
    xfer(1'b1, `CTM_ADDR_LIVE, 32'h5555);
    rdchk(`CTM_ADDR_LIVE, 32'hffff);
    rdchk(`CTM_ADDR_CLEAR, 32'h0);
    rdchk(32'hffff03a0, 32'h0);
    xfer(1'b1, `CTM_ADDR_CONFIG, 32'hffffffff);
    rdchk(`CTM_ADDR_CONFIG, `CTM_CFG_WMASK);
    xfer(1'b1, `CTM_ADDR_RELOAD, 32'h1234);
    rdchk(`CTM_ADDR_RELOAD, 32'h1234);
    xfer(1'b1, `CTM_ADDR_CONFIG, 32'h0);
    $display("Register test done.");
    xfer(1'b1, `CTM_ADDR_MASK, 32'h1);
    for (i = 0; i < 4; i = i + 1) begin
      xfer(1'b1, `CTM_ADDR_RELOAD, {16'h0, ldT[16*i +: 16]});
      xfer(1'b1, `CTM_ADDR_CONFIG, {20'h0, cfT[12*i +: 12]});
      xfer(1'b1, `CTM_ADDR_CONFIG, 32'h0);
      rdchk(`CTM_ADDR_LIVE, {16'h0, exT[16*i +: 16]});
      irqchk(1'b1);
      xfer(1'b1, `CTM_ADDR_CLEAR, i * 32'h3c);
      irqchk(1'b0);
      chk(i + 1, ticks);
    end
    // mask gating: an expiry shows only while unmasked.
    xfer(1'b1, `CTM_ADDR_RELOAD, 32'h1);
    xfer(1'b1, `CTM_ADDR_CONFIG, 32'h80);
    xfer(1'b1, `CTM_ADDR_CONFIG, 32'h0);
    xfer(1'b1, `CTM_ADDR_MASK, 32'h0);
    irqchk(1'b0);
    xfer(1'b1, `CTM_ADDR_MASK, 32'h1);
    irqchk(1'b1);
    xfer(1'b1, `CTM_ADDR_CLEAR, 32'h0);
    irqchk(1'b0);
    chk(5, ticks);
    $display("Count test done.");
    for (i = 0; i < 4; i = i + 1) begin
      xfer(1'b1, `CTM_ADDR_RELOAD, 32'h1000);
      xfer(1'b1, `CTM_ADDR_CONFIG, {24'h0, 4'h8, preT[4*i +: 4]});
      repeat ((i < 2) ? 300 : 20) @(posedge ref_clk);
      xfer(1'b1, `CTM_ADDR_CONFIG, 32'h0);
      rdchk(`CTM_ADDR_LIVE, 32'h1000 - decT[8*i +: 8]);
    end
    xfer(1'b1, `CTM_ADDR_RELOAD, 32'h1000);
    xfer(1'b1, `CTM_ADDR_CONFIG, 32'h280);
    for (i = 0; i < 2; i = i + 1) begin
      repeat (10) @(posedge ref_clk);
      lowPowerOsc <= 1'b1;
      repeat (10) @(posedge ref_clk);
      lowPowerOsc <= 1'b0;
    end
    repeat (10) @(posedge ref_clk);
    xfer(1'b1, `CTM_ADDR_CONFIG, 32'h0);
    rdchk(`CTM_ADDR_LIVE, 32'h0ffe);
    $display("Prescaler test done.");
    for (i = 0; i < 4; i = i + 1) begin
      xfer(1'b1, `CTM_ADDR_CONFIG, ccT[32*i +: 32]);
      xfer(1'b1, `CTM_ADDR_RELOAD, {16'h0, clT[16*i +: 16]});
      pulse(csT[5*i +: 5]);
      rdchk(`CTM_ADDR_CAPTURE, {16'h0, cxT[16*i +: 16]});
    end
    rdchk(`CTM_ADDR_STATUS, 32'h2);
    xfer(1'b1, `CTM_ADDR_STATUS, 32'h2);
    rdchk(`CTM_ADDR_STATUS, 32'h0);
    $display("Capture test done.");
    report_and_stop;
  end
endmodule // tb_top
